// [core/cam_store_defines.svh]
// Constants for the RAM cam table store: object indices, field positions,
// reset values and store geometry.
// Assumes it is included by bare name from the package and the top module.
`ifndef CAM_STORE_DEFINES_SVH
`define CAM_STORE_DEFINES_SVH

// ****************************************************************
// Object dictionary indices
// ****************************************************************
`define IDX_DESIRED_STATE 16'h2300
`define IDX_CAM_CONFIG 16'h2360
`define IDX_RESERVED_SIZE 16'h250A
`define IDX_STORE_POINTER 16'h250B
`define IDX_STORE_DATA 16'h250C

// ****************************************************************
// Store geometry
// ****************************************************************
`define STORE_DEPTH 2048
`define STORE_WIDTH 16
`define STORE_AW 11
`define MAX_TABLES 16

// ****************************************************************
// Field positions and values
// ****************************************************************
`define STATE_CAMMING 16'h0019
`define CFG_TABLE_MSB 3
`define CFG_TABLE_LSB 0
`define CFG_RAM_SRC_BIT 7
`define CFG_INSEL_MSB 11
`define CFG_INSEL_LSB 8
`define CFG_TRIG_MSB 13
`define CFG_TRIG_LSB 12
`define COMP_FLAG_MSB 15
`define COMP_FLAG_LSB 14
`define COMP_FLAG_VAL 2'h1
`define COMP_INC_MSB 13
`define TRIG_CONT 2'h0
`define TRIG_EDGE 2'h1
`define TRIG_LEVEL 2'h2
`define TRIG_INDEX 2'h3
`define RST_WORD16 16'h0000
`define RST_WORD32 32'h00000000

`endif

// [core/cam_store_pkg.sv]
// Types shared by the cam table store files.
// Assumes cam_store_defines.svh is on the include path.
`default_nettype none

package cam_store_pkg;
  `include "cam_store_defines.svh"

  // Cam engine sequencing
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_META0,
    ST_META1,
    ST_HEAD,
    ST_ARM,
    ST_RD,
    ST_LAT,
    ST_EMIT
  } cam_state_e;
endpackage : cam_store_pkg

`default_nettype wire

// [core/cam_store_ram.sv]
// Dual-port table store: port A read/write for the host, port B read only
// for the cam engine. Both ports read synchronously, one cycle latency.
// Assumes a single clock; ce low freezes writes and read registers.
`default_nettype none

module cam_store_ram #(
  parameter int DEPTH = 2048,
  parameter int WIDTH = 16,
  parameter int AW = 11
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic aWe,
  input wire logic [AW-1:0] aAddr,
  input wire logic [WIDTH-1:0] aWdata,
  output logic [WIDTH-1:0] aRdata,
  input wire logic [AW-1:0] bAddr,
  output logic [WIDTH-1:0] bRdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Storage array has no reset; contents are whatever the host loaded
  always_ff @(posedge clk_sys) begin
    if (ce && aWe) begin
      mem[aAddr] <= aWdata;
    end
  end

  // Read registers; reset only so the outputs are defined from the start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aRdata <= '0;
      bRdata <= '0;
    end else if (ce) begin
      aRdata <= mem[aAddr];
      bRdata <= mem[bAddr];
    end
  end
endmodule : cam_store_ram

`default_nettype wire

// [core/ram_cam_table_store.sv]
// RAM cam table store: object access to the table store and the cam engine
// that walks a selected table and hands out master/slave increments.
// Assumes object requests arrive synchronous to clk_sys; camInputs and
// masterIndex come from pins and are synchronised here.
`default_nettype none
`include "cam_store_defines.svh"

module ram_cam_table_store
  import cam_store_pkg::*;
#(
  parameter int DEPTH = `STORE_DEPTH,
  parameter int AW = `STORE_AW
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic objValid,
  input wire logic objWrite,
  input wire logic [15:0] objIndex,
  input wire logic [31:0] objWdata,
  output logic [31:0] objRdata,
  output logic objRvalid,
  input wire logic [15:0] camInputs,
  input wire logic masterIndex,
  input wire logic rowReady,
  output logic rowValid,
  output logic [15:0] masterInc,
  output logic [15:0] slaveInc,
  output logic camActive,
  output logic tableRunning,
  output logic compressedTable
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [15:0] desiredState_reg, desiredState_next;
  logic [15:0] camConfig_reg, camConfig_next;
  logic [15:0] reservedSize_reg, reservedSize_next;
  logic [15:0] storePtr_reg, storePtr_next;
  logic [31:0] regVal_reg, regVal_next;
  logic rdSel_reg, rdSel_next;
  logic rdValid_reg, rdValid_next;
  logic [15:0] inSync1_reg, inSync2_reg, inPrev_reg;
  logic idxSync1_reg, idxSync2_reg, idxPrev_reg;
  cam_state_e state_reg, state_next;
  logic [15:0] rdAddr_reg, rdAddr_next;
  logic [15:0] start_reg, start_next;
  logic [15:0] endAddr_reg, endAddr_next;
  logic [15:0] ptr_reg, ptr_next;
  logic [15:0] master_reg, master_next;
  logic [15:0] slave_reg, slave_next;
  logic haveMaster_reg, haveMaster_next;
  logic comp_reg, comp_next;
  logic dataAcc, ramWe, camming, selIn, trigGo, levelOk;
  logic [1:0] trigMode;
  logic [15:0] ramA, ramB;

  // True when a word offset lies inside the usable store
  function automatic logic inStore(input logic [15:0] addr,
                                   input logic [15:0] rsv);
    inStore = (addr < 16'(DEPTH)) && (addr < rsv);
  endfunction : inStore

  // ****************************************************************
  // Table store
  // ****************************************************************
  cam_store_ram #(
    .DEPTH(DEPTH),
    .WIDTH(`STORE_WIDTH),
    .AW(AW)
  ) u_store (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .aWe(ramWe),
    .aAddr(storePtr_reg[AW-1:0]),
    .aWdata(objWdata[15:0]),
    .aRdata(ramA),
    .bAddr(rdAddr_next[AW-1:0]),
    .bRdata(ramB)
  );

  // ****************************************************************
  // Object access
  // ****************************************************************
  assign dataAcc = objValid && (objIndex == `IDX_STORE_DATA);
  // Out-of-range writes are dropped but still move the pointer
  assign ramWe = dataAcc && objWrite && inStore(storePtr_reg,
                                                 reservedSize_reg);

  // Next values of the host-visible objects and read path
  always_comb begin
    desiredState_next = desiredState_reg;
    camConfig_next = camConfig_reg;
    reservedSize_next = reservedSize_reg;
    storePtr_next = storePtr_reg;
    regVal_next = `RST_WORD32;
    rdSel_next = 1'b0;
    rdValid_next = objValid && !objWrite;
    if (objValid && objWrite) begin
      case (objIndex)
        `IDX_DESIRED_STATE: desiredState_next = objWdata[15:0];
        `IDX_CAM_CONFIG: camConfig_next = objWdata[15:0];
        `IDX_RESERVED_SIZE: reservedSize_next = objWdata[15:0];
        `IDX_STORE_POINTER: storePtr_next = objWdata[15:0];
        default: ;
      endcase
    end
    if (objValid && !objWrite) begin
      case (objIndex)
        `IDX_DESIRED_STATE: regVal_next = {16'h0000, desiredState_reg};
        `IDX_CAM_CONFIG: regVal_next = {16'h0000, camConfig_reg};
        `IDX_RESERVED_SIZE: regVal_next = {16'h0000, reservedSize_reg};
        `IDX_STORE_POINTER: regVal_next = {16'h0000, storePtr_reg};
        `IDX_STORE_DATA:
          rdSel_next = inStore(storePtr_reg, reservedSize_reg);
        default: regVal_next = `RST_WORD32;
      endcase
    end
    if (dataAcc) begin
      storePtr_next = storePtr_reg + 16'h0001;
    end
  end

  // Host object registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      desiredState_reg <= `RST_WORD16;
      camConfig_reg <= `RST_WORD16;
      reservedSize_reg <= `RST_WORD16;
      storePtr_reg <= `RST_WORD16;
      regVal_reg <= `RST_WORD32;
      rdSel_reg <= 1'b0;
      rdValid_reg <= 1'b0;
    end else if (ce) begin
      desiredState_reg <= desiredState_next;
      camConfig_reg <= camConfig_next;
      reservedSize_reg <= reservedSize_next;
      storePtr_reg <= storePtr_next;
      regVal_reg <= regVal_next;
      rdSel_reg <= rdSel_next;
      rdValid_reg <= rdValid_next;
    end
  end

  // Store words are signed increments, so data reads sign-extend
  assign objRdata = rdSel_reg ? {{16{ramA[15]}}, ramA} : regVal_reg;
  assign objRvalid = rdValid_reg && ce;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Second stage feeds all logic; the first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inSync1_reg <= `RST_WORD16;
      inSync2_reg <= `RST_WORD16;
      inPrev_reg <= `RST_WORD16;
      idxSync1_reg <= 1'b0;
      idxSync2_reg <= 1'b0;
      idxPrev_reg <= 1'b0;
    end else if (ce) begin
      inSync1_reg <= camInputs;
      inSync2_reg <= inSync1_reg;
      inPrev_reg <= inSync2_reg;
      idxSync1_reg <= masterIndex;
      idxSync2_reg <= idxSync1_reg;
      idxPrev_reg <= idxSync2_reg;
    end
  end

  // ****************************************************************
  // Cam engine
  // ****************************************************************
  assign camming = (desiredState_reg == `STATE_CAMMING)
                   && camConfig_reg[`CFG_RAM_SRC_BIT];
  assign trigMode = camConfig_reg[`CFG_TRIG_MSB:`CFG_TRIG_LSB];
  assign selIn = inSync2_reg[camConfig_reg[`CFG_INSEL_MSB:`CFG_INSEL_LSB]];
  assign levelOk = (trigMode != `TRIG_LEVEL) || selIn;

  // Trigger decode; index pulses only count while armed
  always_comb begin
    case (trigMode)
      `TRIG_CONT: trigGo = 1'b1;
      `TRIG_EDGE: trigGo = selIn
        && !inPrev_reg[camConfig_reg[`CFG_INSEL_MSB:`CFG_INSEL_LSB]];
      `TRIG_LEVEL: trigGo = selIn;
      `TRIG_INDEX: trigGo = idxSync2_reg && !idxPrev_reg;
      default: trigGo = 1'b0;
    endcase
  end

  // Engine next-state: fetch metadata, classify table, stream rows
  always_comb begin
    state_next = state_reg;
    rdAddr_next = rdAddr_reg;
    start_next = start_reg;
    endAddr_next = endAddr_reg;
    ptr_next = ptr_reg;
    master_next = master_reg;
    slave_next = slave_reg;
    haveMaster_next = haveMaster_reg;
    comp_next = comp_reg;
    rowValid = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (camming) begin
          // Metadata pair of table N sits at 2N
          rdAddr_next = {11'h000,
            camConfig_reg[`CFG_TABLE_MSB:`CFG_TABLE_LSB], 1'b0};
          state_next = ST_META0;
        end
      end
      ST_META0: begin
        start_next = ramB;
        rdAddr_next = rdAddr_reg + 16'h0001;
        state_next = ST_META1;
      end
      ST_META1: begin
        endAddr_next = start_reg + ramB;
        rdAddr_next = start_reg;
        state_next = ST_HEAD;
      end
      ST_HEAD: begin
        comp_next = (ramB[`COMP_FLAG_MSB:`COMP_FLAG_LSB]
                     == `COMP_FLAG_VAL);
        if (comp_next) begin
          master_next = {2'b00, ramB[`COMP_INC_MSB:0]};
        end
        state_next = ST_ARM;
      end
      ST_ARM: begin
        haveMaster_next = 1'b0;
        if (trigGo) begin
          // Compressed tables skip the master word already taken
          ptr_next = comp_reg ? start_reg + 16'h0001 : start_reg;
          state_next = ST_RD;
        end
      end
      ST_RD: begin
        if (ptr_reg >= endAddr_reg) begin
          state_next = ST_ARM;
        end else begin
          rdAddr_next = ptr_reg;
          ptr_next = ptr_reg + 16'h0001;
          state_next = ST_LAT;
        end
      end
      ST_LAT: begin
        if (!comp_reg && !haveMaster_reg) begin
          master_next = ramB;
          haveMaster_next = 1'b1;
          state_next = ST_RD;
        end else begin
          slave_next = ramB;
          state_next = ST_EMIT;
        end
      end
      ST_EMIT: begin
        rowValid = levelOk;
        if (levelOk && rowReady) begin
          haveMaster_next = 1'b0;
          state_next = ST_RD;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Leaving camming or RAM source aborts immediately
    if (!camming) begin
      state_next = ST_IDLE;
      rowValid = 1'b0;
    end
  end

  // Engine registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      rdAddr_reg <= `RST_WORD16;
      start_reg <= `RST_WORD16;
      endAddr_reg <= `RST_WORD16;
      ptr_reg <= `RST_WORD16;
      master_reg <= `RST_WORD16;
      slave_reg <= `RST_WORD16;
      haveMaster_reg <= 1'b0;
      comp_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      rdAddr_reg <= rdAddr_next;
      start_reg <= start_next;
      endAddr_reg <= endAddr_next;
      ptr_reg <= ptr_next;
      master_reg <= master_next;
      slave_reg <= slave_next;
      haveMaster_reg <= haveMaster_next;
      comp_reg <= comp_next;
    end
  end

  // Row increments and the compressed flag come straight from engine flops; camActive and tableRunning decode state_reg
  assign masterInc = master_reg;
  assign slaveInc = slave_reg;
  assign compressedTable = comp_reg;
  assign camActive = (state_reg != ST_IDLE);
  assign tableRunning = (state_reg == ST_RD) || (state_reg == ST_LAT)
                        || (state_reg == ST_EMIT);
endmodule : ram_cam_table_store

`default_nettype wire

// [dv/ram_cam_table_store_props.sv]
// Port checker for the cam table store.
// Assumes one clock; answers are only expected on edges with ce high.
`default_nettype none

module ram_cam_table_store_props #(
  parameter int DEPTH = 2048,
  parameter int AW = 11
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic objValid,
  input wire logic objWrite,
  input wire logic [15:0] objIndex,
  input wire logic [31:0] objWdata,
  input wire logic [31:0] objRdata,
  input wire logic objRvalid,
  input wire logic [15:0] camInputs,
  input wire logic masterIndex,
  input wire logic rowReady,
  input wire logic rowValid,
  input wire logic [15:0] masterInc,
  input wire logic [15:0] slaveInc,
  input wire logic camActive,
  input wire logic tableRunning,
  input wire logic compressedTable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ****************************************************************
  // Object bus answers
  // ****************************************************************
  chk_read_answer: assert property (
    ce && objValid && !objWrite |=> objRvalid)
    else $error("read request got no answer");
  chk_quiet_answer: assert property (
    ce && !(objValid && !objWrite) |=> !objRvalid)
    else $error("answer without a read request");
  chk_reset_clear: assert property (
    $fell(rst) |-> !camActive && !rowValid && !objRvalid)
    else $error("outputs not cleared by reset");
  // ****************************************************************
  // Row stream; the gaps follow the word reads a row needs
  // ****************************************************************
  chk_idle_quiet: assert property (
    !camActive |-> !rowValid && !tableRunning)
    else $error("row offered while engine idle");
  // Compressed tables need the fewest cycles: six before the first row
  chk_start_order: assert property (
    $rose(camActive) |-> !rowValid [*6])
    else $error("row before metadata fetch finished");
  chk_std_gap: assert property (
    rowValid && rowReady && !compressedTable |=> !rowValid [*3])
    else $error("standard row came too soon");
  chk_comp_gap: assert property (
    rowValid && rowReady && compressedTable |=> !rowValid)
    else $error("compressed row came too soon");
  chk_comp_master: assert property (
    rowValid && compressedTable |-> masterInc[15:14] == 2'h0)
    else $error("format flag left in master increment");
  chk_row_hold: assert property (
    rowValid && !rowReady ##1 camActive
      |-> $stable(masterInc) && $stable(slaveInc))
    else $error("row changed before it was taken");
endmodule : ram_cam_table_store_props

bind ram_cam_table_store ram_cam_table_store_props #(
  .DEPTH(DEPTH),
  .AW(AW)
) props (.clk_sys, .rst, .ce, .objValid, .objWrite, .objIndex,
  .objWdata, .objRdata, .objRvalid, .camInputs, .masterIndex,
  .rowReady, .rowValid, .masterInc, .slaveInc, .camActive,
  .tableRunning, .compressedTable);

`default_nettype wire

// [dv/host_model.sv]
// Host controller model: object reads, writes and table loading.
// Assumes reads are answered one cycle after the taking edge.
`default_nettype none

module host_model (
  input wire logic clk_sys,
  output logic objValid,
  output logic objWrite,
  output logic [15:0] objIndex,
  output logic [31:0] objWdata,
  input wire logic [31:0] objRdata,
  input wire logic objRvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    objValid = 1'b0;
    objWrite = 1'b0;
    objIndex = 16'h0000;
    objWdata = 32'h00000000;
  end

  // One request, held for exactly its taking edge; released index and
  // data lines are inverted so nothing can lean on stale values
  task automatic access(input logic wr, input logic [15:0] idx,
      input logic [31:0] d);
    @(posedge clk_sys);
    objValid <= 1'b1;
    objWrite <= wr;
    objIndex <= idx;
    objWdata <= d;
    @(posedge clk_sys);
    objValid <= 1'b0;
    objIndex <= ~idx;
    objWdata <= ~d;
  endtask : access

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    access(1'b1, idx, d);
  endtask : wr

  // Answer is taken only if flagged valid in its cycle
  task automatic rd(input logic [15:0] idx, output logic [31:0] d);
    access(1'b0, idx, 32'h00000000);
    @(posedge clk_sys);
    d = (objRvalid === 1'b1) ? objRdata : 'x;
  endtask : rd

  // Pointer first, then increments in order, never positions
  task automatic load(input logic [15:0] start, input logic [15:0] w[$]);
    wr(16'h250B, {16'h0000, start});
    foreach (w[i]) wr(16'h250C, {16'h0000, w[i]});
  endtask : load
endmodule : host_model

`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the cam table store.
// Assumes the host model and the bound checker are compiled first.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst, ce, objValid, objWrite, masterIndex, rowReady;
  logic [15:0] objIndex, camInputs, masterInc, slaveInc;
  logic [31:0] objWdata, objRdata, rd32;
  logic objRvalid, rowValid, camActive, tableRunning, compressedTable;
  int fails = 0;
  int comparisons = 0;
  // Metadata for two tables, then standard and compressed data
  logic [15:0] words[$] = '{16'h0004, 16'h0004, 16'h0008, 16'h0003,
    16'h0064, 16'h0032, 16'hFFFE, 16'h0003, 16'h4032, 16'h0007,
    16'hFFF9, 16'h1111, 16'h2222};
  logic [15:0] regs[5] = '{16'h2300, 16'h2360, 16'h250A, 16'h250B,
    16'h1234};

  host_model host (.clk_sys, .objValid, .objWrite, .objIndex,
    .objWdata, .objRdata, .objRvalid);
  ram_cam_table_store DUT (.clk_sys, .rst, .ce, .objValid, .objWrite,
    .objIndex, .objWdata, .objRdata, .objRvalid, .camInputs,
    .masterIndex, .rowReady, .rowValid, .masterInc, .slaveInc,
    .camActive, .tableRunning, .compressedTable);

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits a bounded time for a taken row, then compares it
  task automatic getRow(input logic [15:0] m, input logic [15:0] s);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(rowValid === 1'b1 && rowReady === 1'b1) && n < 300);
    chk("rowValid", 32'h00000001, {31'h0, rowValid});
    chk("masterInc", {16'h0000, m}, {16'h0000, masterInc});
    chk("slaveInc", {16'h0000, s}, {16'h0000, slaveInc});
  endtask : getRow

  // Stop, configure, start: a fresh start refetches metadata
  task automatic runCam(input logic [31:0] cfg);
    host.wr(16'h2300, 32'h00000000);
    host.wr(16'h2360, cfg);
    host.wr(16'h2300, 32'h00000019);
  endtask : runCam

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // Cuts a hang short; the tests need a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    end_sim;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    camInputs = 16'h0000;
    masterIndex = 1'b0;
    rowReady = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (regs[i]) begin
      host.rd(regs[i], rd32);
      chk("reset value", 32'h00000000, rd32);
    end
    host.wr(16'h1234, 32'h0000FFFF);
    host.rd(16'h1234, rd32);
    chk("unmapped", 32'h00000000, rd32);
    // Reserve 12 words so the last loaded word is dropped
    host.wr(16'h250A, 32'h0000000C);
    host.load(16'h0000, words);
    host.rd(16'h250B, rd32);
    chk("pointer", 32'h0000000D, rd32);
    // Clock enable low: a pointer write in that time must be lost
    ce <= 1'b0;
    host.wr(16'h250B, 32'h00000005);
    ce <= 1'b1;
    host.rd(16'h250B, rd32);
    chk("frozen pointer", 32'h0000000D, rd32);
    host.wr(16'h250B, 32'h00000000);
    foreach (words[i]) begin
      host.rd(16'h250C, rd32);
      chk("store word", (i < 12) ? {{16{words[i][15]}}, words[i]}
        : 32'h00000000, rd32);
    end
    // Standard table, consumer stalls first
    rowReady <= 1'b0;
    runCam(32'h00000080);
    repeat (20) @(posedge clk_sys);
    rowReady <= 1'b1;
    getRow(16'h0064, 16'h0032);
    getRow(16'hFFFE, 16'h0003);
    getRow(16'h0064, 16'h0032);
    chk("compressed", 32'h00000000, {31'h0, compressedTable});
    // Compressed table number 1
    runCam(32'h00000081);
    getRow(16'h0032, 16'h0007);
    getRow(16'h0032, 16'hFFF9);
    chk("compressed", 32'h00000001, {31'h0, compressedTable});
    // RAM source bit clear keeps the engine idle
    runCam(32'h00000001);
    repeat (15) @(posedge clk_sys);
    chk("camActive", 32'h00000000, {31'h0, camActive});
    // Edge and level triggers on input 3, then the masterIndex trigger
    for (int m = 1; m < 4; m++) begin
      runCam(32'h00000380 | (m << 12));
      repeat (20) @(posedge clk_sys);
      chk("tableRunning", 32'h00000000, {31'h0, tableRunning});
      camInputs <= 16'h0008;
      masterIndex <= 1'b1;
      getRow(16'h0064, 16'h0032);
      camInputs <= 16'h0000;
      masterIndex <= 1'b0;
    end
    end_sim;
  end
endmodule : tb

`default_nettype wire
